// file: hdl/ssoc_pkg.sv
package ssoc_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned SLOW_HZ = 1;
  localparam int unsigned FAST_HZ = 16;
  localparam int unsigned CYC_SLOW = CLK_HZ / SLOW_HZ;
  localparam int unsigned CYC_FAST = CLK_HZ / FAST_HZ;
  localparam int unsigned SMP_W = 12;
  localparam int unsigned OFS_W = 12;
  localparam int unsigned TMP_W = 8;
  localparam logic [OFS_W-1:0] OFS_RST = 12'h000;
  localparam logic [SMP_W-1:0] HYST_RST = 12'h010;
  localparam logic [3:0] INIT_CYC = 4'h4;
  localparam logic [7:0] DUTY_DEAD = 8'h08;

  typedef enum logic [1:0] {
    SSOC_INIT = 2'b00,
    SSOC_START = 2'b01,
    SSOC_NORMAL = 2'b11,
    SSOC_TEST = 2'b10
  } ssoc_state_e;

  typedef struct packed {
    logic signed [OFS_W-1:0] ofs_cold;
    logic signed [OFS_W-1:0] ofs_hot;
    logic [TMP_W-1:0] tmp_cold;
    logic [TMP_W-1:0] tmp_hot;
  } ssoc_cal_s;

  typedef enum logic [1:0] {
    SSOC_REG_INSTANT = 2'b00,
    SSOC_REG_STEP = 2'b01,
    SSOC_REG_SERVO = 2'b11
  } ssoc_regime_e;
endpackage

// file: hdl/ssoc_interp.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------
// linear interpolation between two calibration points
// -----------------------------------------------
module ssoc_interp
  import ssoc_pkg::*;
(
  input wire ssoc_cal_s cal,
  input wire logic [TMP_W-1:0] temp,
  output logic signed [OFS_W-1:0] ofs
);
  logic signed [TMP_W+1:0] span;
  logic signed [TMP_W+1:0] dt;
  logic signed [OFS_W+TMP_W+3:0] prod;
  logic signed [OFS_W+TMP_W+3:0] quot;
  always_comb
  begin
    span = $signed({2'b00, cal.tmp_hot}) - $signed({2'b00, cal.tmp_cold});
    dt = $signed({2'b00, temp}) - $signed({2'b00, cal.tmp_cold});
    prod = (OFS_W+TMP_W+4)'(($signed(cal.ofs_hot) - $signed(cal.ofs_cold)) * dt);
    // degenerate span falls back to cold point, avoids divide by zero
    quot = (span == '0) ? '0 : prod / span;
    ofs = OFS_W'(quot + cal.ofs_cold);
  end
endmodule
`default_nettype wire

// file: hdl/ssoc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssoc_top
  import ssoc_pkg::*;
#(
  parameter int unsigned CYC_SLOW_P = CYC_SLOW,
  parameter int unsigned CYC_FAST_P = CYC_FAST
)(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic signed [SMP_W-1:0] SENSE_SAMPLE,
  input wire logic [TMP_W-1:0] DIE_TEMP,
  input wire ssoc_cal_s CAL_DATA,
  input wire logic SUPPLY_NEGATIVE,
  input wire logic [SMP_W-1:0] NEG_SUPPLY_LEVEL,
  output logic SQUARE_OUT,
  output logic HIGH_CURRENT_LEVEL,
  output logic LOW_CURRENT_LEVEL,
  output logic PRODUCTION_MARGIN_TEST_MODE,
  output logic NORMAL_MODE,
  output logic signed [OFS_W-1:0] OFFSET_CORR,
  output logic [1:0] REGIME
);
  // -----------------------------------------------
  // input synchronisers (analog side is asynchronous)
  // -----------------------------------------------
  logic signed [SMP_W-1:0] smp_s1_reg, smp_reg;
  logic [TMP_W-1:0] tmp_s1_reg, tmp_reg;
  logic neg_s1_reg, neg_reg;
  logic [SMP_W-1:0] nlv_s1_reg, nlv_reg;
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      smp_s1_reg <= '0;
      smp_reg <= '0;
      tmp_s1_reg <= '0;
      tmp_reg <= '0;
      neg_s1_reg <= 1'b0;
      neg_reg <= 1'b0;
      nlv_s1_reg <= '0;
      nlv_reg <= '0;
    end
    else
    begin
      smp_s1_reg <= SENSE_SAMPLE;
      smp_reg <= smp_s1_reg;
      tmp_s1_reg <= DIE_TEMP;
      tmp_reg <= tmp_s1_reg;
      neg_s1_reg <= SUPPLY_NEGATIVE;
      neg_reg <= neg_s1_reg;
      nlv_s1_reg <= NEG_SUPPLY_LEVEL;
      nlv_reg <= nlv_s1_reg;
    end
  end

  // -----------------------------------------------
  // temperature target from calibration
  // -----------------------------------------------
  logic signed [OFS_W-1:0] target;
  ssoc_interp u_interp (
    .cal(CAL_DATA),
    .temp(tmp_reg),
    .ofs(target)
  );

  // -----------------------------------------------
  // comparator with hysteresis
  // -----------------------------------------------
  logic signed [SMP_W+1:0] corr_sig;
  logic sq_reg, sq_next;
  always_comb
  begin
    corr_sig = (SMP_W+2)'(smp_reg) - (SMP_W+2)'(OFFSET_CORR);
    if (PRODUCTION_MARGIN_TEST_MODE)
      corr_sig = corr_sig + $signed({2'b00, nlv_reg});
    sq_next = sq_reg;
    if (corr_sig > $signed({2'b00, HYST_RST}))
      sq_next = 1'b1;
    else if (corr_sig < -$signed({2'b00, HYST_RST}))
      sq_next = 1'b0;
  end
  logic rise;
  assign rise = sq_next & ~sq_reg;

  // -----------------------------------------------
  // period and duty timer
  // -----------------------------------------------
  logic [31:0] per_cnt_reg, per_cnt_next;
  logic [31:0] hi_cnt_reg, hi_cnt_next;
  logic [31:0] last_per_reg, last_per_next;
  logic [31:0] last_hi_reg, last_hi_next;
  logic per_valid_reg, per_valid_next;
  always_comb
  begin
    per_cnt_next = per_cnt_reg;
    hi_cnt_next = hi_cnt_reg;
    last_per_next = last_per_reg;
    last_hi_next = last_hi_reg;
    per_valid_next = per_valid_reg;
    if (rise)
    begin
      last_per_next = per_cnt_reg + 32'h1;
      last_hi_next = hi_cnt_reg;
      per_cnt_next = '0;
      hi_cnt_next = '0;
      per_valid_next = 1'b1;
    end
    else
    begin
      // saturate: a stalled wheel reads as very slow
      if (per_cnt_reg < CYC_SLOW_P)
        per_cnt_next = per_cnt_reg + 32'h1;
      else
        per_valid_next = 1'b0;
      if (sq_reg && hi_cnt_reg < CYC_SLOW_P)
        hi_cnt_next = hi_cnt_reg + 32'h1;
    end
  end

  ssoc_regime_e regime;
  always_comb
  begin
    if (!per_valid_reg || last_per_reg >= CYC_SLOW_P)
      regime = SSOC_REG_INSTANT;
    else if (last_per_reg >= CYC_FAST_P)
      regime = SSOC_REG_STEP;
    else
      regime = SSOC_REG_SERVO;
  end

  // -----------------------------------------------
  // sequencing and offset control
  // -----------------------------------------------
  ssoc_state_e st_reg, st_next;
  logic [3:0] init_reg, init_next;
  logic signed [OFS_W-1:0] ofs_reg, ofs_next;
  logic signed [OFS_W-1:0] trim_reg, trim_next;
  logic signed [OFS_W-1:0] want;
  logic [32:0] twice_hi;
  always_comb
  begin
    st_next = st_reg;
    init_next = init_reg;
    ofs_next = ofs_reg;
    trim_next = trim_reg;
    twice_hi = {last_hi_reg, 1'b0};
    want = OFS_W'(target + trim_reg);
    case (st_reg)
      SSOC_INIT:
      begin
        // let synchronisers fill before trusting temperature
        if (init_reg == INIT_CYC)
          st_next = SSOC_START;
        else
          init_next = init_reg + 4'h1;
      end
      SSOC_START:
      begin
        ofs_next = target;
        st_next = SSOC_NORMAL;
      end
      SSOC_NORMAL:
      begin
        if (regime == SSOC_REG_INSTANT)
        begin
          ofs_next = want;
          trim_next = '0;
        end
        else if (rise)
        begin
          if (regime == SSOC_REG_SERVO)
          begin
            // full-width signed one: a one-bit signed literal reads as minus one
            if (twice_hi > {1'b0, last_per_reg} + {25'h0, DUTY_DEAD})
              trim_next = trim_reg + 12'sh001;
            else if (twice_hi + {25'h0, DUTY_DEAD} < {1'b0, last_per_reg})
              trim_next = trim_reg - 12'sh001;
          end
          if (want > ofs_reg)
            ofs_next = ofs_reg + 12'sh001;
          else if (want < ofs_reg)
            ofs_next = ofs_reg - 12'sh001;
        end
        if (neg_reg)
          st_next = SSOC_TEST;
      end
      SSOC_TEST:
      begin
        if (!neg_reg)
          st_next = SSOC_INIT;
        init_next = '0;
      end
      default:
        st_next = SSOC_INIT;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_reg <= SSOC_INIT;
      init_reg <= '0;
      ofs_reg <= OFS_RST;
      trim_reg <= '0;
      sq_reg <= 1'b0;
      per_cnt_reg <= '0;
      hi_cnt_reg <= '0;
      last_per_reg <= '0;
      last_hi_reg <= '0;
      per_valid_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      init_reg <= init_next;
      ofs_reg <= ofs_next;
      trim_reg <= trim_next;
      sq_reg <= sq_next;
      per_cnt_reg <= per_cnt_next;
      hi_cnt_reg <= hi_cnt_next;
      last_per_reg <= last_per_next;
      last_hi_reg <= last_hi_next;
      per_valid_reg <= per_valid_next;
    end
  end

  // -----------------------------------------------
  // outputs
  // -----------------------------------------------
  logic out_gate;
  assign out_gate = (st_reg == SSOC_NORMAL) || (st_reg == SSOC_TEST);
  assign SQUARE_OUT = sq_reg & out_gate;
  assign HIGH_CURRENT_LEVEL = sq_reg & out_gate;
  assign LOW_CURRENT_LEVEL = ~(sq_reg & out_gate);
  assign PRODUCTION_MARGIN_TEST_MODE = (st_reg == SSOC_TEST);
  assign NORMAL_MODE = (st_reg == SSOC_NORMAL);
  assign OFFSET_CORR = ofs_reg;
  assign REGIME = regime;

  // -----------------------------------------------
  // assertions
  // -----------------------------------------------
  property p_start_to_normal;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_reg == SSOC_START) |=> (st_reg == SSOC_NORMAL) && (ofs_reg == $past(target));
  endproperty
  a_start_to_normal: assert property (p_start_to_normal)
    else $error("start did not load target and enter normal");

  property p_init_bounded;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_reg == SSOC_INIT) && !neg_reg |-> ##[1:6] (st_reg == SSOC_START);
  endproperty
  a_init_bounded: assert property (p_init_bounded)
    else $error("init sequence did not finish in time");

  property p_step_limit;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_reg == SSOC_NORMAL) && (regime != SSOC_REG_INSTANT) && $past(st_reg) == SSOC_NORMAL
      |=> (($signed(ofs_reg) - $signed($past(ofs_reg)) <= 1) &&
           ($signed($past(ofs_reg)) - $signed(ofs_reg) <= 1));
  endproperty
  a_step_limit: assert property (p_step_limit)
    else $error("offset moved more than one step");

  property p_step_only_on_edge;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_reg == SSOC_NORMAL) && (regime != SSOC_REG_INSTANT) && !rise |=> $stable(ofs_reg);
  endproperty
  a_step_only_on_edge: assert property (p_step_only_on_edge)
    else $error("offset changed without a period edge");

  property p_instant;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_reg == SSOC_NORMAL) && (regime == SSOC_REG_INSTANT) && !neg_reg
      |=> (ofs_reg == $past(want));
  endproperty
  a_instant: assert property (p_instant)
    else $error("slow regime did not apply offset at once");

  property p_servo_off;
    @(posedge CLOCK) disable iff (!RST_N)
    (regime != SSOC_REG_SERVO) && (st_reg == SSOC_NORMAL) && (regime == SSOC_REG_STEP)
      |=> $stable(trim_reg);
  endproperty
  a_servo_off: assert property (p_servo_off)
    else $error("duty loop active below threshold");

  property p_current_levels;
    @(posedge CLOCK) disable iff (!RST_N)
    HIGH_CURRENT_LEVEL != LOW_CURRENT_LEVEL && (HIGH_CURRENT_LEVEL == SQUARE_OUT);
  endproperty
  a_current_levels: assert property (p_current_levels)
    else $error("current level does not follow output");

  property p_test_entry;
    @(posedge CLOCK) disable iff (!RST_N)
    (st_reg == SSOC_NORMAL) && neg_reg |=> PRODUCTION_MARGIN_TEST_MODE;
  endproperty
  a_test_entry: assert property (p_test_entry)
    else $error("negative supply did not enter test mode");

  property p_hyst_hold;
    @(posedge CLOCK) disable iff (!RST_N)
    (corr_sig <= $signed({2'b00, HYST_RST})) && (corr_sig >= -$signed({2'b00, HYST_RST}))
      |=> $stable(sq_reg);
  endproperty
  a_hyst_hold: assert property (p_hyst_hold)
    else $error("comparator toggled inside hysteresis band");

  c_normal: cover property (@(posedge CLOCK) disable iff (!RST_N) st_reg == SSOC_NORMAL);
  c_servo: cover property (@(posedge CLOCK) disable iff (!RST_N) regime == SSOC_REG_SERVO);
  c_step: cover property (@(posedge CLOCK) disable iff (!RST_N) regime == SSOC_REG_STEP && rise);
  c_test: cover property (@(posedge CLOCK) disable iff (!RST_N) PRODUCTION_MARGIN_TEST_MODE);
endmodule
`default_nettype wire

// file: tb/ssoc_detect.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// detection circuit across the load resistor
// ----------------------------------------
module ssoc_detect
(
  input wire logic CLOCK,
  input wire logic HIGH_CURRENT_LEVEL,
  input wire logic LOW_CURRENT_LEVEL,
  input wire logic clr,
  output logic det_level,
  output logic det_bad,
  output int pulse_cnt
);
  logic last;
  // exactly one current level at a time, the high one reads as 1
  assign det_level = HIGH_CURRENT_LEVEL & ~LOW_CURRENT_LEVEL;
  assign det_bad = HIGH_CURRENT_LEVEL === LOW_CURRENT_LEVEL;
  // sampled on the falling edge, clear of the launch edge
  always @(negedge CLOCK)
  begin
    if (clr)
      pulse_cnt <= 0;
    else if (det_level && !last)
      pulse_cnt <= pulse_cnt + 1;
    last <= det_level;
  end
endmodule
`default_nettype wire

// file: tb/speed_sensor_offset_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module speed_sensor_offset_control_tb_top;
  import ssoc_pkg::*;
  logic CLOCK = 0, RST_N = 0, SUPPLY_NEGATIVE = 0, clr = 0, mon = 0;
  logic signed [SMP_W-1:0] SENSE_SAMPLE = '0;
  logic [TMP_W-1:0] DIE_TEMP = 8'h40;
  logic [SMP_W-1:0] NEG_SUPPLY_LEVEL = '0;
  ssoc_cal_s CAL_DATA = '{12'sh028, 12'sh078, 8'h20, 8'h60};
  logic SQUARE_OUT, HIGH_CURRENT_LEVEL, LOW_CURRENT_LEVEL;
  logic PRODUCTION_MARGIN_TEST_MODE, NORMAL_MODE, det_level, det_bad, pq;
  logic signed [OFS_W-1:0] OFFSET_CORR, po;
  logic [1:0] REGIME;
  int err_count = 0, n_tests = 0, pulse_cnt, nchg, tgt, k;
  int hs[$] = '{97, 85, 63, 75};
  int he[$] = '{1, 1, 0, 0};
  ssoc_top #(.CYC_SLOW_P(400), .CYC_FAST_P(50)) dut (.CLOCK(CLOCK), .RST_N(RST_N),
    .SENSE_SAMPLE(SENSE_SAMPLE), .DIE_TEMP(DIE_TEMP), .CAL_DATA(CAL_DATA),
    .SUPPLY_NEGATIVE(SUPPLY_NEGATIVE), .NEG_SUPPLY_LEVEL(NEG_SUPPLY_LEVEL),
    .SQUARE_OUT(SQUARE_OUT), .HIGH_CURRENT_LEVEL(HIGH_CURRENT_LEVEL),
    .LOW_CURRENT_LEVEL(LOW_CURRENT_LEVEL),
    .PRODUCTION_MARGIN_TEST_MODE(PRODUCTION_MARGIN_TEST_MODE),
    .NORMAL_MODE(NORMAL_MODE), .OFFSET_CORR(OFFSET_CORR), .REGIME(REGIME));
  ssoc_detect det (.CLOCK(CLOCK), .HIGH_CURRENT_LEVEL(HIGH_CURRENT_LEVEL),
    .LOW_CURRENT_LEVEL(LOW_CURRENT_LEVEL), .clr(clr), .det_level(det_level),
    .det_bad(det_bad), .pulse_cnt(pulse_cnt));
  initial forever #2 CLOCK = ~CLOCK;
  // ----------------------------------------
  // helpers and reference model
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  // linear two-point offset versus temperature
  function int e_ofs(input int t);
    return 40 + (t - 32) * 80 / 64;
  endfunction
  task wave(input int per, input int hi, input int amp, input int base, input int n);
    repeat (n)
    begin
      SENSE_SAMPLE = 12'(base + amp);
      cyc(hi);
      SENSE_SAMPLE = 12'(base - amp);
      cyc(per - hi);
    end
  endtask
  task wait_normal;
    for (int i = 0; i < 30 && NORMAL_MODE !== 1'b1; i++)
      cyc(1);
  endtask
  // at most one single-step change per output period
  always @(negedge CLOCK)
  begin
    if (SQUARE_OUT && !pq)
      nchg = 0;
    if (mon && OFFSET_CORR !== po && REGIME !== 2'b00)
    begin
      nchg++;
      chk(nchg <= 1 && (OFFSET_CORR - po == 1 || po - OFFSET_CORR == 1), 1);
    end
    pq = SQUARE_OUT;
    po = OFFSET_CORR;
  end
  initial
  begin
    #100us;
    err_count++;
    test_done();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(67));
    cyc(3);
    chk({SQUARE_OUT, HIGH_CURRENT_LEVEL, LOW_CURRENT_LEVEL}, 3'b001);
    chk({PRODUCTION_MARGIN_TEST_MODE, NORMAL_MODE, REGIME, OFFSET_CORR}, 0);
    cyc(3);
    RST_N = 1;
    cyc(10);
    chk(NORMAL_MODE, 1);
    chk(OFFSET_CORR, 12'(e_ofs(8'h40)));
    DIE_TEMP = 8'h60;
    cyc(8);
    chk(OFFSET_CORR, 12'(e_ofs(8'h60)));
    chk(REGIME, 2'b00);
    DIE_TEMP = 8'h40;
    cyc(8);
    // hysteresis band is 16 around the corrected zero
    foreach (hs[i])
    begin
      SENSE_SAMPLE = 12'(hs[i]);
      cyc(5);
      chk(SQUARE_OUT, he[i]);
      chk({HIGH_CURRENT_LEVEL, det_level, det_bad}, {{2{1'(he[i])}}, 1'b0});
    end
    SUPPLY_NEGATIVE = 1;
    cyc(6);
    chk({PRODUCTION_MARGIN_TEST_MODE, NORMAL_MODE}, 2'b10);
    // supply sweep: zero keeps pulses, a large level swamps them
    for (k = 0; k < 2; k++)
    begin
      NEG_SUPPLY_LEVEL = k ? 12'(200 + $urandom % 300) : 12'h000;
      cyc(4);
      clr = 1;
      cyc(2);
      clr = 0;
      wave(40, 20, 100, 80, 10);
      chk(k ? pulse_cnt <= 1 : pulse_cnt >= 9, 1);
    end
    chk(OFFSET_CORR, 12'(e_ofs(8'h40)));
    SUPPLY_NEGATIVE = 0;
    SENSE_SAMPLE = '0;
    cyc(3);
    wait_normal();
    chk(NORMAL_MODE, 1);
    mon = 1;
    wave(100, 50, 300, 0, 3);
    chk(REGIME, 2'b01);
    DIE_TEMP = 8'(8'h40 + 4 * (1 + $urandom % 3));
    tgt = e_ofs(DIE_TEMP);
    wave(100, 50, 300, 0, 20);
    chk(OFFSET_CORR, 12'(tgt));
    // 80 percent duty, twice the high time clears the duty deadband
    wave(20, 16, 300, 0, 3);
    chk(REGIME, 2'b11);
    wave(20, 16, 300, 0, 40);
    chk(OFFSET_CORR > tgt, 1);
    mon = 0;
    SENSE_SAMPLE = '0;
    cyc(900);
    chk(REGIME, 2'b00);
    chk(OFFSET_CORR, 12'(tgt));
    test_done();
  end
endmodule
`default_nettype wire
